// ---- spike_pkg.sv ----
// Package: register map, field layout, reset values and constants
//------------------------------------------------------------------
// What this block does
// - Keep an 8-bit spike limit, reset 7; suppress SCL/SDA pulses not longer.
// - Spike limit register sits at 0xa0; bits 31:8 reserved.
// - Spike limit writes take effect only while controller enable bit 0 is clear.
// - A written spike limit below one stores one instead.
// - Reading 0xa8 clears restart flag, raw status bit 12; reads bit 0 zero.
// - Component parameter register at 0xf4 reads all zeros.
// - Component version register at 0xf8 returns a fixed constant.
// - Component type register at 0xfc: two letter bytes plus 16-bit number.
//------------------------------------------------------------------
package spike_pkg;
  localparam logic [7:0] OFS_ENABLE     = 8'h6c;
  localparam logic [7:0] OFS_RAW_STATUS = 8'h34;
  localparam logic [7:0] OFS_INT_MASK   = 8'h30;
  localparam logic [7:0] OFS_INT_STATUS = 8'h2c;
  localparam logic [7:0] OFS_SPIKE      = 8'ha0;
  localparam logic [7:0] OFS_RST_CLEAR  = 8'ha8;
  localparam logic [7:0] OFS_COMP_PARAM = 8'hf4;
  localparam logic [7:0] OFS_COMP_VER   = 8'hf8;
  localparam logic [7:0] OFS_COMP_TYPE  = 8'hfc;
  localparam int         SPIKE_W        = 8;
  localparam logic [7:0] SPIKE_RESET    = 8'h07;
  localparam logic [7:0] SPIKE_MIN      = 8'h01;
  localparam int         RESTART_BIT    = 12;
  localparam int         ENABLE_BIT     = 0;
  localparam int         EV_W           = 13;
  // Event bits in status and mask registers
  localparam int         EV_RESTART     = 12;
  localparam int         EV_SCL_SPIKE   = 1;
  localparam int         EV_SDA_SPIKE   = 0;
  // Arbitrary neutral identity values
  localparam logic [31:0] COMP_VER_VALUE  = 32'h0001_0000;
  localparam logic [31:0] COMP_TYPE_VALUE = 32'h5858_0001;
endpackage

// ---- pin_sync.sv ----
// Two-flop synchroniser for one external line
`timescale 1ns/1ps
module pin_sync
(
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_pin,
  output logic      o_sync
);
  logic meta_r;

  // Second flop only reads the first
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      meta_r <= 1'b1;
      o_sync <= 1'b1;
    end
    else
    begin
      meta_r <= i_pin;
      o_sync <= meta_r;
    end
  end
endmodule

// ---- spike_filter.sv ----
// Spike filter for one bus line, counting core clocks
`timescale 1ns/1ps
module spike_filter
  import spike_pkg::*;
#(
  parameter int W = SPIKE_W
)
(
  input  wire logic         i_mclk,
  input  wire logic         i_reset,
  input  wire logic         i_line,
  input  wire logic [W-1:0] i_limit,
  output logic              o_line,
  output logic              o_spike
);
  logic [W-1:0] cnt_r;
  wire          differs = (i_line != o_line);

  // Line must differ for more than limit cycles to pass
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt_r   <= '0;
      o_line  <= 1'b1;
      o_spike <= 1'b0;
    end
    else
    begin
      o_spike <= 1'b0;
      if (differs && cnt_r >= i_limit)
      begin
        o_line <= i_line;
        cnt_r  <= '0;
      end
      else if (differs)
        cnt_r <= cnt_r + 1'b1;
      else
      begin
        o_spike <= (cnt_r != '0);
        cnt_r   <= '0;
      end
    end
  end
endmodule

// ---- spike_regs.sv ----
// Spike filter limit, restart clear and identity registers on APB
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module spike_regs
  import spike_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic        i_restart_event,
  output logic             o_scl_filt,
  output logic             o_sda_filt,
  output logic             o_controller_enable,
  output logic [7:0]       o_spike_length_limit,
  output logic             o_irq
);
  //------------------------------------------------------------------
  // Register state
  //------------------------------------------------------------------
  logic              enable_r;
  logic [7:0]        spike_r;
  logic [EV_W-1:0]   status_r;
  logic [EV_W-1:0]   mask_r;
  logic              access_r;
  logic              scl_s;
  logic              sda_s;
  logic              scl_spike;
  logic              sda_spike;

  //------------------------------------------------------------------
  // Decode
  //------------------------------------------------------------------
  wire        setup   = i_psel && !i_penable;
  // Access edge: ready is sampled high here, so writes land here only
  wire        access  = i_psel && i_penable && access_r;
  wire        wr      = access && i_pwrite;
  wire        rd      = setup && !i_pwrite;
  wire        rd_acc  = access && !i_pwrite;
  wire        hit_en  = (i_paddr == OFS_ENABLE);
  wire        hit_raw = (i_paddr == OFS_RAW_STATUS);
  wire        hit_msk = (i_paddr == OFS_INT_MASK);
  wire        hit_int = (i_paddr == OFS_INT_STATUS);
  wire        hit_spk = (i_paddr == OFS_SPIKE);
  wire        hit_rcl = (i_paddr == OFS_RST_CLEAR);
  wire        hit_par = (i_paddr == OFS_COMP_PARAM);
  wire        hit_ver = (i_paddr == OFS_COMP_VER);
  wire        hit_typ = (i_paddr == OFS_COMP_TYPE);
  wire        mapped  = hit_en | hit_raw | hit_msk | hit_int | hit_spk
                      | hit_rcl | hit_par | hit_ver | hit_typ;
  wire [7:0]  wr_spk  = i_pwdata[7:0];
  wire [7:0]  spk_nxt = (wr_spk < SPIKE_MIN) ? SPIKE_MIN : wr_spk;
  wire        spk_we  = wr && hit_spk && !enable_r;
  wire [EV_W-1:0] ev_set;
  wire [EV_W-1:0] ev_clr;

  // Events: restart and suppressed spikes
  assign ev_set = ({{(EV_W-1){1'b0}}, 1'b0}
                 | ({{(EV_W-1){1'b0}}, i_restart_event} << EV_RESTART)
                 | ({{(EV_W-1){1'b0}}, scl_spike} << EV_SCL_SPIKE)
                 | ({{(EV_W-1){1'b0}}, sda_spike} << EV_SDA_SPIKE));
  // Write-one-to-clear, plus restart clear on read
  assign ev_clr = ((wr && hit_int) ? i_pwdata[EV_W-1:0] : '0)
                | ((rd_acc && hit_rcl) ? (EV_W'(1) << RESTART_BIT)
                                   : '0);

  // Read mux; unlisted bits read zero
  wire [31:0] rd_data =
      hit_en  ? {31'h0000_0000, enable_r} :
      hit_raw ? {19'h0_0000, status_r} :
      hit_msk ? {19'h0_0000, mask_r} :
      hit_int ? {19'h0_0000, status_r & mask_r} :
      hit_spk ? {24'h00_0000, spike_r} :
      hit_rcl ? 32'h0000_0000 :
      hit_par ? 32'h0000_0000 :
      hit_ver ? COMP_VER_VALUE :
      hit_typ ? COMP_TYPE_VALUE : 32'h0000_0000;

  //------------------------------------------------------------------
  // Line synchronisers and filters
  //------------------------------------------------------------------
  pin_sync u_scl_sync
  (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_pin   (i_scl),
    .o_sync  (scl_s)
  );
  pin_sync u_sda_sync
  (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_pin   (i_sda),
    .o_sync  (sda_s)
  );
  spike_filter u_scl_filt
  (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_line  (scl_s),
    .i_limit (spike_r),
    .o_line  (o_scl_filt),
    .o_spike (scl_spike)
  );
  spike_filter u_sda_filt
  (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_line  (sda_s),
    .i_limit (spike_r),
    .o_line  (o_sda_filt),
    .o_spike (sda_spike)
  );

  //------------------------------------------------------------------
  // Control registers
  //------------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      enable_r <= 1'b0;
      spike_r  <= SPIKE_RESET;
      mask_r   <= '0;
    end
    else
    begin
      if (wr && hit_en)
        enable_r <= i_pwdata[ENABLE_BIT];
      if (spk_we)
        spike_r <= spk_nxt;
      if (wr && hit_msk)
        mask_r <= i_pwdata[EV_W-1:0];
    end
  end

  // Sticky status: set wins over clear
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      status_r <= '0;
    else
      status_r <= (status_r & ~ev_clr) | ev_set;
  end

  // APB answer one cycle after setup
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      access_r  <= 1'b0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end
    else
    begin
      access_r  <= setup;
      o_pready  <= setup;
      o_pslverr <= setup && !mapped;
      o_prdata  <= rd ? rd_data : 32'h0000_0000;
    end
  end

  // Mirrors and interrupt
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_controller_enable  <= 1'b0;
      o_spike_length_limit <= SPIKE_RESET;
      o_irq                <= 1'b0;
    end
    else
    begin
      o_controller_enable  <= enable_r;
      o_spike_length_limit <= spike_r;
      o_irq                <= |(status_r & mask_r);
    end
  end
endmodule

// ---- spike_regs_sva.sv ----
// Port checker for the spike limit and identity register block
`timescale 1ns/1ps
module spike_regs_chk
  import spike_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_reset,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic        i_scl,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_scl_filt,
  input wire logic        o_controller_enable,
  input wire logic [7:0]  o_spike_length_limit
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // Read completing in this cycle
  wire rd_done = i_psel && i_penable && !i_pwrite && o_pready;
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  a_ready_next: assert property (s_setup |=> o_pready)
    else $error("no ready after setup");
  a_ready_only: assert property (o_pready |-> $past(i_psel && !i_penable))
    else $error("ready without setup");
  a_limit_min: assert property (o_spike_length_limit != 8'h00)
    else $error("limit below one");
  a_limit_locked: assert property (o_controller_enable &&
    $past(o_controller_enable) |-> $stable(o_spike_length_limit))
    else $error("limit changed while enabled");
  a_clear_zero: assert property (rd_done && i_paddr == OFS_RST_CLEAR
    |-> o_prdata == 32'h0000_0000) else $error("clear read not zero");
  a_param_zero: assert property (rd_done && i_paddr == OFS_COMP_PARAM
    |-> o_prdata == 32'h0000_0000) else $error("param read not zero");
  a_version_fixed: assert property (rd_done && i_paddr == OFS_COMP_VER
    |-> o_prdata == COMP_VER_VALUE) else $error("version wrong");
  a_type_fixed: assert property (rd_done && i_paddr == OFS_COMP_TYPE
    |-> o_prdata == COMP_TYPE_VALUE) else $error("type wrong");
  a_filter_steady: assert property ($changed(o_scl_filt)
    |-> $past(i_scl, 3) == o_scl_filt) else $error("filter passed glitch");
endmodule
bind spike_regs spike_regs_chk u_chk (.i_mclk(i_mclk), .i_reset(i_reset),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_scl(i_scl), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_scl_filt(o_scl_filt),
  .o_controller_enable(o_controller_enable),
  .o_spike_length_limit(o_spike_length_limit));

// ---- bus_party.sv ----
// Model of other bus parties pulling the shared lines low
`timescale 1ns/1ps
module bus_party
(
  input  wire logic i_mclk,
  output logic      o_scl,
  output logic      o_sda
);
  // Released lines sit at the pull-up level
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Pull one line low for len clocks, then release
  task automatic pull_low(input bit on_sda, input int len);
    @(posedge i_mclk);
    o_sda <= !on_sda;
    o_scl <= on_sda;
    repeat (len) @(posedge i_mclk);
    o_scl <= 1'b1;
    o_sda <= 1'b1;
  endtask
endmodule

// ---- spike_regs_bench.sv ----
// Self-checking bench for the spike limit register block
`timescale 1ns/1ps
module spike_regs_bench;
  import spike_pkg::*;
  logic        i_mclk, i_reset, i_psel, i_penable, i_pwrite, i_restart_event;
  logic [7:0]  i_paddr, o_spike_length_limit;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, o_scl_filt, o_sda_filt, o_irq, err;
  logic        o_controller_enable, scl, sda, low;
  int          fail_count, checks;
  spike_regs u_spike_regs (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_scl(scl), .i_sda(sda),
    .i_restart_event(i_restart_event), .o_scl_filt(o_scl_filt),
    .o_sda_filt(o_sda_filt), .o_controller_enable(o_controller_enable),
    .o_spike_length_limit(o_spike_length_limit), .o_irq(o_irq));
  bus_party u_bus_party (.i_mclk(i_mclk), .o_scl(scl), .o_sda(sda));
  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
      begin
        fail_count++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
  endtask
  // One APB transfer; waits for ready, then releases
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_mclk);
    end
    while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_mclk);
  endtask
  // Glitch one line and note whether the filtered line dropped
  task watch(input bit on_sda, input int len);
    low = 1'b0;
    fork
      u_bus_party.pull_low(on_sda, len);
      repeat (30)
      begin
        @(posedge i_mclk);
        if ((on_sda ? o_sda_filt : o_scl_filt) !== 1'b1)
          low = 1'b1;
      end
    join
  endtask
  task pulse_restart;
    i_restart_event <= 1'b1;
    @(posedge i_mclk);
    i_restart_event <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask
  task t_ids;
    apb(0, OFS_SPIKE, 0);
    chk(rd, 32'h0000_0007);
    apb(0, OFS_COMP_PARAM, 0);
    chk(rd, 32'h0000_0000);
    apb(1, OFS_COMP_TYPE, 0);
    apb(0, OFS_COMP_TYPE, 0);
    chk(rd, COMP_TYPE_VALUE);
    apb(0, OFS_COMP_VER, 0);
    chk(rd, COMP_VER_VALUE);
    apb(0, 8'h04, 0);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("ids done");
  endtask
  task t_limit;
    apb(1, OFS_SPIKE, 32'hFFFF_FF00);
    apb(0, OFS_SPIKE, 0);
    chk(rd, 32'h0000_0001);
    apb(1, OFS_SPIKE, 32'h0000_0005);
    apb(1, OFS_ENABLE, 32'h0000_0001);
    apb(1, OFS_SPIKE, 32'h0000_0009);
    apb(0, OFS_SPIKE, 0);
    chk(rd, 32'h0000_0005);
    chk(o_spike_length_limit, 32'h0000_0005);
    chk(o_controller_enable, 1'b1);
    apb(1, OFS_ENABLE, 32'h0000_0000);
    $display("limit done");
  endtask
  task t_filter;
    watch(1'b1, 5);
    chk(low, 1'b0);
    watch(1'b0, 8);
    chk(low, 1'b1);
    apb(0, OFS_RAW_STATUS, 0);
    chk(rd[1:0], 2'b01);
    watch(1'b0, 5);
    chk(low, 1'b0);
    watch(1'b1, 6);
    chk(low, 1'b1);
    apb(0, OFS_RAW_STATUS, 0);
    chk(rd[1:0], 2'b11);
    $display("filter done");
  endtask
  task t_irq;
    apb(1, OFS_INT_MASK, 32'h0000_1000);
    pulse_restart;
    chk(o_irq, 1'b1);
    apb(0, OFS_RST_CLEAR, 0);
    repeat (2) @(posedge i_mclk);
    chk(rd, 32'h0000_0000);
    chk(o_irq, 1'b0);
    apb(1, OFS_INT_MASK, 32'h0000_0000);
    pulse_restart;
    chk(o_irq, 1'b0);
    apb(1, OFS_INT_STATUS, 32'h0000_1000);
    apb(0, OFS_RAW_STATUS, 0);
    chk(rd[12], 1'b0);
    $display("irq done");
  endtask
  task print_verdict;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    {i_reset, i_psel, i_penable, i_pwrite, i_restart_event} = 5'b10000;
    i_paddr = 8'h00;
    i_pwdata = 32'h0000_0000;
    repeat (20) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    t_ids;
    t_limit;
    t_filter;
    t_irq;
    print_verdict;
  end
  initial
  begin
    #200000;
    fail_count++;
    print_verdict;
  end
endmodule
